// ==== relay_cfg_pkg.sv ====
package relay_cfg_pkg;
   // Bus geometry
   localparam int ADDR_W = 6;
   // Register byte offsets
   localparam logic [5:0] OFS_OOS     = 6'h00;
   localparam logic [5:0] OFS_RECLOSE = 6'h04;
   localparam logic [5:0] OFS_FLTLOC  = 6'h08;
   localparam logic [5:0] OFS_INPUT   = 6'h0C;
   localparam logic [5:0] OFS_STATUS  = 6'h10;
   localparam logic [5:0] OFS_GROUP   = 6'h14;
   // Oos control fields
   localparam int ZSEL_LSB  = 0;
   localparam int OSBSEL_LSB = 2;
   localparam int ZFLAG_LSB = 4;
   localparam int ANGLE_LSB = 8;
   localparam int Z4FWD_BIT = 16;
   // Angle limits in degrees
   localparam logic [7:0] ANGLE_MIN = 8'h1E;
   localparam logic [7:0] ANGLE_MAX = 8'h82;
   localparam logic [7:0] ANGLE_RST = 8'h46;
   // Fault location fields: lock in 0.1 s, reset in minutes
   localparam int LOCK_LSB  = 0;
   localparam int RESET_LSB = 16;
   localparam logic [9:0] LOCK_MAX  = 10'h3E7;
   localparam logic [9:0] RESET_MAX = 10'h3E7;
   localparam logic [15:0] FLTLOC_FULL = 16'hFFFF;
   // Input mode and group fields
   localparam int MODE_LSB = 0;
   localparam int GSEL_LSB = 4;
   localparam logic [3:0] MODE_MAX = 4'h8;
   localparam logic [3:0] MODE_RST = 4'h3;
   localparam logic [2:0] GSEL_MAX = 3'h4;
   localparam logic [2:0] GSEL_RST = 3'h1;
   // Scheme code for blocking scheme
   localparam logic [2:0] SCHEME_BLOCK = 3'h4;
   // Timing
   localparam int CLK_HZ        = 10_000_000;
   localparam int SWING_MS      = 30;
   localparam int SWING_CYC     = CLK_HZ / 1000 * SWING_MS;
   localparam int TENTH_S_CYC   = CLK_HZ / 10;
   localparam int MINUTE_TENTHS = 600;
   localparam int TBC_CYC       = 16;
   // Zone selector codes
   typedef enum logic [1:0] {
      ZONE2 = 2'b00,
      ZONE3 = 2'b01,
      ZONE4 = 2'b10
   } coord_zone_t;
   // Out-of-step block codes
   typedef enum logic [1:0] {
      BLOCK_EVERY_TRIP       = 2'b00,
      BLOCK_DISTANCE_CHANNEL = 2'b01,
      BLOCK_PHASE_DISTANCE   = 2'b10,
      BLOCK_NOTHING          = 2'b11
   } oos_block_t;
   // Group change states
   typedef enum logic [1:0] {
      GRP_IDLE  = 2'b00,
      GRP_CHECK = 2'b01,
      GRP_APPLY = 2'b10
   } grp_state_t;
endpackage : relay_cfg_pkg

// ==== relay_blocking_input_group_select.sv ====
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module relay_blocking_input_group_select
   import relay_cfg_pkg::*;
#(
   parameter int RESET_TENTHS_PER_MIN = MINUTE_TENTHS,
   parameter int TENTH_CYCLES         = TENTH_S_CYC,
   parameter int SWING_CYCLES         = SWING_CYC
)(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Station contact pins
   input  wire logic              config_contact_a,
   input  wire logic              config_contact_b,
   input  wire logic              config_contact_c,
   // Protection functions
   input  wire logic              swing_inside,
   input  wire logic [3:0]        zone_trip_req,
   input  wire logic              channel_trip_req,
   input  wire logic              overcurrent_trip_req,
   input  wire logic [8:0]        reclose_src,
   input  wire logic              line_pickup_trip,
   input  wire logic              reclose_initiate_req,
   input  wire logic              fault_event,
   input  wire logic [15:0]       fault_location,
   input  wire logic              carrier_start_req,
   input  wire logic              pilot_trip_req,
   input  wire logic [2:0]        pilot_scheme_select,
   input  wire logic              relay_on_line,
   input  wire logic              trip_check_ok,
   // Outputs to protection and station
   output logic                   out_of_step_detect,
   output logic [1:0]             coord_zone,
   output logic [7:0]             swing_char_angle,
   output logic [3:0]             zone_trip_out,
   output logic                   channel_trip_out,
   output logic                   overcurrent_trip_out,
   output logic                   reclose_initiate,
   output logic                   reclose_cancel,
   output logic [15:0]            supervisory_analog_output,
   output logic                   fault_type_contacts_open,
   output logic                   pilot_receiver_two,
   output logic                   oscillography_trigger,
   output logic [2:0]             config_input,
   output logic                   pilot_trip_out,
   output logic                   carrier_start_contact,
   output logic                   carrier_stop_contact,
   output logic [1:0]             active_group,
   output logic                   trip_bus_check,
   output logic                   config_error
);
   initial begin
      if (SWING_CYCLES < 1 || TENTH_CYCLES < 1 || RESET_TENTHS_PER_MIN < 1)
         $error("Timing parameters must be at least one");
   end

   // Pin synchronisers
   logic [2:0] pinMeta_q, pinSync_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinMeta_q <= 3'h0;
         pinSync_q <= 3'h0;
      end else begin
         pinMeta_q <= {config_contact_c, config_contact_b, config_contact_a};
         pinSync_q <= pinMeta_q;
      end
   end
   wire contactA = pinSync_q[0];
   wire contactB = pinSync_q[1];
   wire contactC = pinSync_q[2];

   // Settings registers
   logic [1:0] zoneSel_q;
   logic [1:0] osbSel_q;
   logic [3:0] zoneFlag_q;
   logic [7:0] angle_q;
   logic       z4Fwd_q;
   logic [9:0] rbEnable_q;
   logic [9:0] lockSet_q;
   logic [9:0] resetSet_q;
   logic [3:0] mode_q;
   logic [2:0] gsel_q;

   // AXI write path
   logic       awHeld_q, wHeld_q;
   logic [ADDR_W-1:0] awAddr_q;
   logic [31:0] wData_q;
   logic       bvalid_q;
   logic [1:0] bresp_q;
   assign s_axi_awready = !awHeld_q && !bvalid_q;
   assign s_axi_wready  = !wHeld_q && !bvalid_q;
   wire awHit   = s_axi_awvalid && s_axi_awready;
   wire wHit    = s_axi_wvalid && s_axi_wready;
   wire haveAw  = awHeld_q || awHit;
   wire haveW   = wHeld_q || wHit;
   wire doWrite = haveAw && haveW && !bvalid_q;
   wire [ADDR_W-1:0] wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
   wire [31:0] wrData = wHeld_q ? wData_q : s_axi_wdata;
   wire wrOos   = doWrite && wrAddr == OFS_OOS;
   wire wrRecl  = doWrite && wrAddr == OFS_RECLOSE;
   wire wrFlt   = doWrite && wrAddr == OFS_FLTLOC;
   wire wrInput = doWrite && wrAddr == OFS_INPUT;
   wire wrMapped = wrOos || wrRecl || wrFlt || wrInput;

   // Field checks on write
   wire [1:0] newZone  = wrData[ZSEL_LSB +: 2];
   wire [7:0] newAngle = wrData[ANGLE_LSB +: 8];
   wire       newZ4Fwd = wrData[Z4FWD_BIT];
   wire zoneOk  = newZone != 2'h3 && (newZone != ZONE4 || newZ4Fwd);
   wire angleOk = newAngle >= ANGLE_MIN && newAngle <= ANGLE_MAX;
   wire [9:0] newLock  = wrData[LOCK_LSB +: 10];
   wire [9:0] newReset = wrData[RESET_LSB +: 10];
   wire fltOk   = newLock <= LOCK_MAX && newReset <= RESET_MAX;
   wire [3:0] newMode = wrData[MODE_LSB +: 4];
   wire [2:0] newGsel = wrData[GSEL_LSB +: 3];
   wire inputOk = newMode <= MODE_MAX && newGsel <= GSEL_MAX;
   wire wrOk = (wrOos && zoneOk && angleOk) || wrRecl || (wrFlt && fltOk)
               || (wrInput && inputOk);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
         awAddr_q <= '0;
         wData_q  <= 32'h0;
         bvalid_q <= 1'b0;
         bresp_q  <= 2'h0;
      end else begin
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= wrMapped ? (wrOk ? 2'h0 : 2'h2) : 2'h3;
         end else begin
            if (awHit) begin
               awHeld_q <= 1'b1;
               awAddr_q <= s_axi_awaddr;
            end
            if (wHit) begin
               wHeld_q <= 1'b1;
               wData_q <= s_axi_wdata;
            end
            if (bvalid_q && s_axi_bready)
               bvalid_q <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // Settings; one copy serves all four groups
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         zoneSel_q  <= ZONE2;
         osbSel_q   <= BLOCK_DISTANCE_CHANNEL;
         zoneFlag_q <= 4'hF;
         angle_q    <= ANGLE_RST;
         z4Fwd_q    <= 1'b0;
         rbEnable_q <= 10'h001;
         lockSet_q  <= 10'h064;
         resetSet_q <= 10'h005;
         mode_q     <= MODE_RST;
         gsel_q     <= GSEL_RST;
      end else begin
         if (wrOos && zoneOk && angleOk) begin
            zoneSel_q  <= newZone;
            osbSel_q   <= wrData[OSBSEL_LSB +: 2];
            zoneFlag_q <= wrData[ZFLAG_LSB +: 4];
            angle_q    <= newAngle;
            z4Fwd_q    <= newZ4Fwd;
         end
         if (wrRecl)
            rbEnable_q <= wrData[9:0];
         if (wrFlt && fltOk) begin
            lockSet_q  <= newLock;
            resetSet_q <= newReset;
         end
         if (wrInput && inputOk) begin
            mode_q <= newMode;
            gsel_q <= newGsel;
         end
      end
   end

   // Swing pickup timer
   logic [$clog2(SWING_CYCLES+1)-1:0] swingCnt_q;
   logic oos_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         swingCnt_q <= '0;
         oos_q      <= 1'b0;
      end else if (!swing_inside) begin
         swingCnt_q <= '0;
         oos_q      <= 1'b0;
      end else if (swingCnt_q == SWING_CYCLES[$bits(swingCnt_q)-1:0] - 1'b1) begin
         oos_q <= 1'b1;
      end else begin
         swingCnt_q <= swingCnt_q + 1'b1;
      end
   end
   assign out_of_step_detect = oos_q;
   assign coord_zone         = zoneSel_q;
   assign swing_char_angle   = angle_q;

   // Trip blocking
   wire block_every_trip   = oos_q && osbSel_q == BLOCK_EVERY_TRIP;
   wire blkZones = oos_q && (osbSel_q == BLOCK_DISTANCE_CHANNEL
                   || osbSel_q == BLOCK_PHASE_DISTANCE);
   wire blkChan  = oos_q && osbSel_q == BLOCK_DISTANCE_CHANNEL;
   wire [3:0] zoneBlock = block_every_trip ? 4'hF : (blkZones ? zoneFlag_q : 4'h0);

   // Reclose blocking
   wire [8:0] rbActive = rbEnable_q[0] ? 9'h1FF : rbEnable_q[9:1];
   wire recloseBlock = |(reclose_src & rbActive) || line_pickup_trip;

   // Input routing
   wire [1:0] modeRow = mode_q >= 4'h6 ? 2'h2 : (mode_q >= 4'h3 ? 2'h1 : 2'h0);
   wire [1:0] modeCol = 2'(mode_q - {modeRow, 1'b0} - {2'h0, modeRow});
   wire useRcvr  = modeCol == 2'h0;
   wire useTrig  = modeCol == 2'h1;
   wire useCfgA  = modeCol == 2'h2;
   wire useGrp   = modeRow == 2'h0;
   wire useStop  = modeRow == 2'h1;
   wire useCfgBC = modeRow == 2'h2;
   wire blockScheme = pilot_scheme_select == SCHEME_BLOCK;
   wire stopIn   = blockScheme && useStop && contactB;
   wire blkPilot = blockScheme && useStop && contactC;
   wire stopCarrier = stopIn || blkPilot;

   // Group selection
   wire [1:0] pinGroup = {contactB, contactC};
   wire [1:0] wantGroup = gsel_q == 3'h0 ? pinGroup : 2'(gsel_q - 3'h1);
   assign config_error = useGrp ? gsel_q != 3'h0 : gsel_q == 3'h0;

   grp_state_t grpState_q;
   logic [1:0] group_q, pendGroup_q;
   logic [$clog2(TBC_CYC+1)-1:0] tbcCnt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         grpState_q  <= GRP_IDLE;
         group_q     <= 2'h0;
         pendGroup_q <= 2'h0;
         tbcCnt_q    <= '0;
      end else begin
         case (grpState_q)
            GRP_IDLE: begin
               if (wantGroup != group_q && !config_error) begin
                  pendGroup_q <= wantGroup;
                  tbcCnt_q    <= '0;
                  grpState_q  <= relay_on_line ? GRP_CHECK : GRP_APPLY;
               end
            end
            GRP_CHECK: begin
               if (trip_check_ok || tbcCnt_q == TBC_CYC[$bits(tbcCnt_q)-1:0])
                  grpState_q <= GRP_APPLY;
               else
                  tbcCnt_q <= tbcCnt_q + 1'b1;
            end
            GRP_APPLY: begin
               group_q    <= pendGroup_q;
               grpState_q <= GRP_IDLE;
            end
            default: grpState_q <= GRP_IDLE;
         endcase
      end
   end
   assign active_group   = group_q;
   assign trip_bus_check = grpState_q == GRP_CHECK;

   // Fault location lock and reset
   logic [$clog2(TENTH_CYCLES+1)-1:0] tenthCnt_q;
   logic [9:0]  lockCnt_q;
   logic [9:0]  minTenth_q;
   logic [9:0]  minCnt_q;
   logic [15:0] flt_q;
   logic        contactsOpen_q;
   wire tick = tenthCnt_q == TENTH_CYCLES[$bits(tenthCnt_q)-1:0] - 1'b1;
   wire locked = lockCnt_q != 10'h0;
   wire take = fault_event && !locked;
   wire minTick = tick && minTenth_q == RESET_TENTHS_PER_MIN[9:0] - 10'h1;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tenthCnt_q     <= '0;
         lockCnt_q      <= 10'h0;
         minTenth_q     <= 10'h0;
         minCnt_q       <= 10'h0;
         flt_q          <= FLTLOC_FULL;
         contactsOpen_q <= 1'b1;
      end else begin
         tenthCnt_q <= tick ? '0 : tenthCnt_q + 1'b1;
         if (take) begin
            flt_q          <= fault_location;
            contactsOpen_q <= 1'b0;
            lockCnt_q      <= lockSet_q;
            minTenth_q     <= 10'h0;
            minCnt_q       <= 10'h0;
         end else begin
            if (tick && locked)
               lockCnt_q <= lockCnt_q - 10'h1;
            if (!contactsOpen_q && resetSet_q != 10'h0) begin
               if (minTick) begin
                  minTenth_q <= 10'h0;
                  minCnt_q   <= minCnt_q + 10'h1;
               end else if (tick)
                  minTenth_q <= minTenth_q + 10'h1;
               if (minCnt_q >= resetSet_q) begin
                  flt_q          <= FLTLOC_FULL;
                  contactsOpen_q <= 1'b1;
               end
            end
         end
      end
   end

   // Registered outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         zone_trip_out        <= 4'h0;
         channel_trip_out     <= 1'b0;
         overcurrent_trip_out <= 1'b0;
         reclose_initiate     <= 1'b0;
         reclose_cancel       <= 1'b0;
         pilot_receiver_two   <= 1'b0;
         oscillography_trigger<= 1'b0;
         config_input         <= 3'h0;
         pilot_trip_out       <= 1'b0;
         carrier_start_contact<= 1'b0;
         carrier_stop_contact <= 1'b0;
      end else begin
         zone_trip_out        <= zone_trip_req & ~zoneBlock;
         channel_trip_out     <= channel_trip_req && !block_every_trip && !blkChan;
         overcurrent_trip_out <= overcurrent_trip_req && !block_every_trip;
         reclose_initiate     <= reclose_initiate_req && !recloseBlock;
         reclose_cancel       <= recloseBlock;
         pilot_receiver_two   <= useRcvr && contactA;
         oscillography_trigger<= useTrig && contactA;
         config_input         <= {useCfgBC && contactC, useCfgBC && contactB,
                                  useCfgA && contactA};
         pilot_trip_out       <= pilot_trip_req && !blkPilot && !block_every_trip && !blkChan;
         carrier_start_contact<= carrier_start_req && !stopCarrier;
         carrier_stop_contact <= stopCarrier;
      end
   end
   assign supervisory_analog_output = flt_q;
   assign fault_type_contacts_open  = contactsOpen_q;

   // AXI read path
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   wire [31:0] rdOos = {15'h0, z4Fwd_q, angle_q, zoneFlag_q, osbSel_q, zoneSel_q};
   wire [31:0] rdStatus = {22'h0, group_q, contactsOpen_q, trip_bus_check, config_error,
                           oos_q, pinSync_q, locked};
   wire rdHit = s_axi_arvalid && s_axi_arready;
   wire rdMapped = s_axi_araddr == OFS_OOS || s_axi_araddr == OFS_RECLOSE
                   || s_axi_araddr == OFS_FLTLOC || s_axi_araddr == OFS_INPUT
                   || s_axi_araddr == OFS_STATUS || s_axi_araddr == OFS_GROUP;
   wire [31:0] rdMux =
      s_axi_araddr == OFS_OOS     ? rdOos :
      s_axi_araddr == OFS_RECLOSE ? {22'h0, rbEnable_q} :
      s_axi_araddr == OFS_FLTLOC  ? {6'h0, resetSet_q, 6'h0, lockSet_q} :
      s_axi_araddr == OFS_INPUT   ? {25'h0, gsel_q, mode_q} :
      s_axi_araddr == OFS_STATUS  ? rdStatus :
      s_axi_araddr == OFS_GROUP   ? {16'h0, flt_q} : 32'h0;
   assign s_axi_arready = !rvalid_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0;
         rresp_q  <= 2'h0;
      end else if (rdHit) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rdMux;
         rresp_q  <= rdMapped ? 2'h0 : 2'h3;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;
endmodule : relay_blocking_input_group_select
`default_nettype wire

// ==== relay_cfg_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module relay_cfg_sva
   import relay_cfg_pkg::*;
#(
   parameter int SWING_CYCLES = SWING_CYC
)(
   // Watched ports
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        swing_inside,
   input wire logic        out_of_step_detect,
   input wire logic [3:0]  zone_trip_req,
   input wire logic [3:0]  zone_trip_out,
   input wire logic        reclose_initiate,
   input wire logic        reclose_cancel,
   input wire logic        fault_event,
   input wire logic [15:0] fault_location,
   input wire logic [15:0] supervisory_analog_output,
   input wire logic        fault_type_contacts_open,
   input wire logic        pilot_receiver_two,
   input wire logic        oscillography_trigger,
   input wire logic [2:0]  config_input,
   input wire logic        carrier_start_contact,
   input wire logic        carrier_stop_contact,
   input wire logic        trip_bus_check
);
   logic [31:0] swingCnt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) swingCnt_q <= 32'h0;
      else swingCnt_q <= swing_inside ? swingCnt_q + 32'h1 : 32'h0;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_oos_on; swingCnt_q == SWING_CYCLES |-> out_of_step_detect; endproperty
   a_oos_on: assert property (p_oos_on) else $error("swing detect late");
   property p_zone; (zone_trip_out & ~$past(zone_trip_req)) == 4'h0; endproperty
   a_zone: assert property (p_zone) else $error("zone trip without request");
   property p_recl; !(reclose_initiate && reclose_cancel); endproperty
   a_recl: assert property (p_recl) else $error("initiate and cancel together");
   property p_carr; carrier_stop_contact |-> !carrier_start_contact; endproperty
   a_carr: assert property (p_carr) else $error("start closed with stop");
   property p_full; $rose(fault_type_contacts_open) |-> supervisory_analog_output == FLTLOC_FULL;
   endproperty
   a_full: assert property (p_full) else $error("reset without full scale");
   property p_load; $changed(supervisory_analog_output) && supervisory_analog_output != FLTLOC_FULL
      |-> $past(fault_event) && supervisory_analog_output == $past(fault_location); endproperty
   a_load: assert property (p_load) else $error("location changed without fault");
   property p_role; $onehot0({pilot_receiver_two, oscillography_trigger, config_input[0]});
   endproperty
   a_role: assert property (p_role) else $error("first input in two roles");
   property p_tbc; trip_bus_check |-> ##[1:20] !trip_bus_check; endproperty
   a_tbc: assert property (p_tbc) else $error("trip check stuck");
   c_oos: cover property ($rose(out_of_step_detect));
   c_tbc: cover property ($rose(trip_bus_check));
   c_full: cover property ($rose(fault_type_contacts_open));
endmodule : relay_cfg_sva
bind relay_blocking_input_group_select relay_cfg_sva #(.SWING_CYCLES(SWING_CYCLES)) sva_u (.*);
`default_nettype wire

// ==== station_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module station_model (
   // Bench side and station side
   input  wire logic       clk,
   input  wire logic [2:0] pins,
   input  wire logic       tbc,
   output logic            contactA,
   output logic            contactB,
   output logic            contactC,
   output logic            checkOk
);
   logic [1:0] wait_q;
   assign {contactC, contactB, contactA} = pins;
   always_ff @(posedge clk) begin
      wait_q <= tbc ? wait_q + 2'h1 : 2'h0;
      checkOk <= tbc && wait_q == 2'h3;
   end
endmodule : station_model
`default_nettype wire

// ==== relay_blocking_input_group_select_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module relay_blocking_input_group_select_bench
   import relay_cfg_pkg::*;
;
   localparam int SWC = 5;
   logic clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fault_event;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, zone_trip_req, zone_trip_out;
   logic [1:0] s_axi_bresp, s_axi_rresp, coord_zone, active_group;
   logic config_contact_a, config_contact_b, config_contact_c, swing_inside, channel_trip_req;
   logic overcurrent_trip_req, line_pickup_trip, reclose_initiate_req, carrier_start_req;
   logic pilot_trip_req, relay_on_line, trip_check_ok, out_of_step_detect, channel_trip_out;
   logic overcurrent_trip_out, reclose_initiate, reclose_cancel, fault_type_contacts_open;
   logic pilot_receiver_two, oscillography_trigger, pilot_trip_out, carrier_start_contact;
   logic carrier_stop_contact, trip_bus_check, config_error;
   logic [8:0] reclose_src;
   logic [15:0] fault_location, supervisory_analog_output;
   logic [2:0] pilot_scheme_select, config_input, pins;
   logic [7:0] swing_char_angle;
   int errCount = 0;
   int checkCount = 0;
   relay_blocking_input_group_select #(.RESET_TENTHS_PER_MIN(3), .TENTH_CYCLES(4),
      .SWING_CYCLES(SWC)) dut_u (.*);
   station_model sta_u (.clk(clk), .pins(pins), .tbc(trip_bus_check), .contactA(config_contact_a),
      .contactB(config_contact_b), .contactC(config_contact_c), .checkOk(trip_check_ok));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checkCount++;
      if (g !== e) begin
         errCount++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic testDone;
      if (errCount == 0 && checkCount > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : testDone
   task automatic tmo(input int n);
      if (n >= 50) begin
         errCount++;
         testDone();
      end
   endtask : tmo
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic axiWr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      n = 0;
      while ((s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid) && n < 50) begin
         @(posedge clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      tmo(n);
      chk("bresp", r, s_axi_bresp);
      s_axi_bready <= 1'b0;
   endtask : axiWr
   task automatic axiRd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      n = 0;
      while ((s_axi_arvalid || !s_axi_rvalid) && n < 50) begin
         @(posedge clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      tmo(n);
      chk("rdata", d, s_axi_rdata);
      chk("rresp", r, s_axi_rresp);
      s_axi_rready <= 1'b0;
   endtask : axiRd
   task automatic pulse(input logic [15:0] v);
      {fault_event, fault_location} <= {1'b1, v};
      @(posedge clk);
      fault_event <= 1'b0;
      cyc(2);
   endtask : pulse
   task automatic checkRegs;
      axiRd(OFS_OOS, 32'h46F4, 2'h0);
      axiRd(OFS_FLTLOC, 32'h50064, 2'h0);
      axiRd(OFS_INPUT, 32'h13, 2'h0);
      axiRd(6'h18, 32'h0, 2'h3);
      axiWr(OFS_OOS, 32'h4F13, 2'h2);
      axiWr(OFS_OOS, 32'h4F12, 2'h2);
      axiWr(OFS_OOS, 32'h1D14, 2'h2);
      axiWr(OFS_OOS, 32'h8314, 2'h2);
      axiWr(OFS_INPUT, 32'h19, 2'h2);
      axiRd(OFS_OOS, 32'h46F4, 2'h0);
   endtask : checkRegs
   task automatic checkOos;
      logic [1:0] c;
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         axiWr(OFS_OOS, {15'h0, 1'b1, 8'h46, 4'h5, c, 2'h2}, 2'h0);
         swing_inside <= 1'b1;
         cyc(SWC - 2);
         chk("oos", 1'b0, out_of_step_detect);
         cyc(5);
         chk("oos", 1'b1, out_of_step_detect);
         chk("zsel", 2'h2, coord_zone);
         chk("angle", 8'h46, swing_char_angle);
         chk("zone", (c == 2'h0) ? 4'h0 : (c == 2'h3) ? 4'hF : 4'hA, zone_trip_out);
         chk("chan", c[1], channel_trip_out);
         chk("oc", c != 2'h0, overcurrent_trip_out);
         chk("pilot", c[1], pilot_trip_out);
         swing_inside <= 1'b0;
         cyc(3);
      end
   endtask : checkOos
   task automatic checkReclose;
      axiWr(OFS_RECLOSE, 32'h8, 2'h0);
      {reclose_initiate_req, reclose_src} <= {1'b1, 9'h004};
      cyc(3);
      chk("cancel", 1'b1, reclose_cancel);
      reclose_src <= 9'h008;
      cyc(3);
      chk("initiate", 1'b1, reclose_initiate);
      axiWr(OFS_RECLOSE, 32'h1, 2'h0);
      cyc(3);
      chk("cancel", 1'b1, reclose_cancel);
   endtask : checkReclose
   task automatic checkFault;
      axiWr(OFS_FLTLOC, 32'h10002, 2'h0);
      pulse(16'h1234);
      pulse(16'h5678);
      chk("loc", 16'h1234, supervisory_analog_output);
      chk("open", 1'b0, fault_type_contacts_open);
      cyc(10);
      pulse(16'h0ABC);
      cyc(6);
      chk("loc", 16'h0ABC, supervisory_analog_output);
      cyc(12);
      chk("loc", 16'hFFFF, supervisory_analog_output);
      chk("open", 1'b1, fault_type_contacts_open);
   endtask : checkFault
   task automatic checkPins;
      logic [3:0] m;
      int n;
      {pins, pilot_scheme_select, carrier_start_req} <= {3'b011, SCHEME_BLOCK, 1'b1};
      for (int i = 0; i < 9; i++) begin
         m = 4'(i);
         axiWr(OFS_INPUT, {25'h0, (m < 4'h3) ? 3'h0 : 3'h1, m}, 2'h0);
         cyc(6);
         chk("role", 3'b001 << (i % 3),
            {config_input[0], oscillography_trigger, pilot_receiver_two});
         chk("cin", {1'b0, m > 4'h5}, config_input[2:1]);
         chk("stop", m inside {[4'h3:4'h5]}, carrier_stop_contact);
         chk("start", !(m inside {[4'h3:4'h5]}), carrier_start_contact);
         chk("grp", (m < 4'h3) ? 2'h2 : 2'h0, active_group);
      end
      pins <= 3'b101;
      axiWr(OFS_INPUT, 32'h14, 2'h0);
      cyc(6);
      chk("pilot", 1'b0, pilot_trip_out);
      chk("stop", 1'b1, carrier_stop_contact);
      axiWr(OFS_INPUT, 32'h10, 2'h0);
      cyc(2);
      chk("cfgerr", 1'b1, config_error);
      relay_on_line <= 1'b1;
      axiWr(OFS_INPUT, 32'h43, 2'h0);
      n = 0;
      while (!trip_bus_check && n < 50) begin
         @(posedge clk);
         n++;
      end
      tmo(n);
      chk("grp", 2'h0, active_group);
      cyc(30);
      chk("grp", 2'h3, active_group);
   endtask : checkPins
   initial begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, swing_inside, reclose_src, fault_event} = '0;
      {fault_location, pilot_scheme_select, pins, line_pickup_trip, relay_on_line} = '0;
      {reclose_initiate_req, carrier_start_req} = '0;
      {zone_trip_req, channel_trip_req, overcurrent_trip_req, pilot_trip_req} = 7'h7F;
      s_axi_wstrb = 4'hF;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      checkRegs();
      checkOos();
      checkReclose();
      checkFault();
      checkPins();
      testDone();
   end
endmodule : relay_blocking_input_group_select_bench
`default_nettype wire
